/* verilog/bsw_pkg.sv */
// constants shared by the backup module status word block
package bsw_pkg;

    // image table footprint of the module
    localparam int BSW_IMAGE_POINTS = 32;
    localparam int BSW_WORD_W = 16;
    localparam logic BSW_SEL_EXT = 1'h0;
    localparam logic BSW_SEL_CHAN = 1'h1;

    // extended status word fields (octal bit 10 is binary bit 8)
    localparam int BSW_EXT_BT_LSB = 0;
    localparam int BSW_EXT_BT_W = 8;
    localparam int BSW_EXT_PEER_OLD_BIT = 8;
    localparam int BSW_EXT_FAST_BIT = 9;
    localparam int BSW_EXT_RSV_LSB = 10;
    localparam int BSW_EXT_RSV_W = 4;
    localparam int BSW_EXT_SWDIAG_BIT = 14;
    localparam int BSW_EXT_EXPAN_BIT = 15;

    // channel status word fields
    localparam int BSW_CH_GROUP_W = 4;
    localparam int BSW_CH_SW_W = 3;
    localparam int BSW_CH_COUNT = 4;
    localparam int BSW_CH_BASE_FIRST = 2;
    localparam int BSW_CH_ERR_POS = 3;

    // block transfer system status word role bit
    localparam int BSW_SYS_ROLE_BIT = 14;

    // network node addresses
    localparam int BSW_NODE_W = 6;
    localparam logic [5:0] BSW_NODE_STEP = 6'h01;

    // reset values
    localparam logic [15:0] BSW_WORD_RST = 16'h0000;
    localparam logic [5:0] BSW_NODE_RST = 6'h00;

    // access point session states
    typedef enum logic [0:0] {
        BSW_SESS_IDLE,
        BSW_SESS_OPEN
    } bsw_sess_e;

endpackage

/* verilog/bsw_status_words.sv */
// auxiliary status words, role bit and secondary access point of the backup module
// What this block does
// - one slot as 32-point module: two input and two output image words
// - all 32 output image bits are ignored; only input words carry data
// - extended word slot-mapped; low byte block-transfer use; octal 12-15 read zero
// - octal bit 10 set when partner module is older hardware revision
// - octal bit 11 shows fast mode; data valid per block, else per segment
// - octal bit 16 normally zero; one during switchover means replace module
// - octal bit 17 set when a backup expansion module is present
// - channel word at right-most slot of first group; channel config and errors
// - octal 10-17 base channels; 00-07 expansion channels, only when fitted
// - each nibble: three config switch states, top bit channel error
// - primary answers at node n+1 and relays to secondary processor
// - secondary module emulates network presence to its processor
// - access path carries programming only, one terminal at a time
// - remote program mode on primary forces a switchover
// - system status bit 14 is one on primary, zero on secondary
`timescale 1ns/1ps
module bsw_status_words
    import bsw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // backplane image scan
    input wire logic scan_rd_in,
    input wire logic scan_word_sel_in,
    input wire logic scan_wr_in,
    input wire logic [BSW_WORD_W-1:0] scan_wr_data_in,
    output logic [BSW_WORD_W-1:0] scan_data_out,
    output logic scan_valid_out,
    // module state feeding the status words
    input wire logic [BSW_EXT_BT_W-1:0] bt_status_byte_in,
    input wire logic peer_old_rev_in,
    input wire logic fast_mode_in,
    input wire logic switchover_active_in,
    input wire logic hw_fault_in,
    input wire logic expansion_present_in,
    input wire logic [BSW_CH_COUNT*BSW_CH_SW_W-1:0] channel_config_switches_in,
    input wire logic [BSW_CH_COUNT-1:0] channel_error_in,
    input wire logic primary_role_in,
    // inter module link block events
    input wire logic block_rcvd_in,
    input wire logic segment_done_in,
    input wire logic last_block_read_in,
    output logic data_valid_out,
    output logic role_primary_out,
    // network access point
    input wire logic [BSW_NODE_W-1:0] node_addr_in,
    input wire logic net_rx_valid_in,
    input wire logic [BSW_NODE_W-1:0] net_rx_dest_in,
    input wire logic [BSW_NODE_W-1:0] net_rx_src_in,
    input wire logic net_rx_is_prog_in,
    input wire logic net_rx_end_in,
    output logic net_relay_out,
    output logic net_reject_out,
    output logic presence_emul_out,
    // processor mode
    input wire logic remote_prog_req_in,
    output logic switchover_req_out
);

    typedef struct packed {
        logic [BSW_WORD_W-1:0] ext_word;
        logic [BSW_WORD_W-1:0] chan_word;
        logic [BSW_WORD_W-1:0] scan_data;
        logic scan_valid;
        logic swdiag;
        logic data_valid;
        logic role_primary;
        bsw_sess_e sess;
        logic [BSW_NODE_W-1:0] sess_owner;
        logic relay;
        logic reject;
        logic presence;
        logic switchover_req;
    } bsw_state_s;

    bsw_state_s state_reg;
    bsw_state_s state_next;

    // the access node wraps past the top address, as node numbers do on the network
    logic [BSW_NODE_W-1:0] access_node;
    logic to_access_node;
    logic owner_match;
    wire logic [BSW_WORD_W-1:0] chan_live;

    // one nibble per channel, order 2B,2A,1B,1A from low to high
    // the expansion pair reads zero while its module is absent, so stale switches never show
    for (genvar ch = 0; ch < BSW_CH_COUNT; ch++) begin : g_chan
        logic fitted;
        assign fitted = (ch >= BSW_CH_BASE_FIRST) || expansion_present_in;
        assign chan_live[ch*BSW_CH_GROUP_W +: BSW_CH_SW_W] =
            fitted ? channel_config_switches_in[ch*BSW_CH_SW_W +: BSW_CH_SW_W] : '0;
        assign chan_live[ch*BSW_CH_GROUP_W + BSW_CH_ERR_POS] =
            fitted && channel_error_in[ch];
    end

    always_comb begin
        state_next = state_reg;
        access_node = node_addr_in + BSW_NODE_STEP;
        to_access_node = net_rx_valid_in && (net_rx_dest_in == access_node);
        owner_match = (net_rx_src_in == state_reg.sess_owner);

        // extended status word rebuilt every cycle from live state
        // octal image bits 10..17 sit on binary bits 8..15 of the word
        state_next.ext_word = BSW_WORD_RST;
        state_next.ext_word[BSW_EXT_BT_LSB +: BSW_EXT_BT_W] = bt_status_byte_in;
        state_next.ext_word[BSW_EXT_PEER_OLD_BIT] = peer_old_rev_in;
        state_next.ext_word[BSW_EXT_FAST_BIT] = fast_mode_in;
        state_next.ext_word[BSW_EXT_RSV_LSB +: BSW_EXT_RSV_W] = '0;
        state_next.ext_word[BSW_EXT_EXPAN_BIT] = expansion_present_in;

        // the diagnostic stays caught for the whole switchover so a scan cannot miss it
        // outside a switchover the bit carries no meaning, so it is cleared there
        if (!switchover_active_in) begin
            state_next.swdiag = 1'b0;
        end else if (hw_fault_in) begin
            state_next.swdiag = 1'b1;
        end
        state_next.ext_word[BSW_EXT_SWDIAG_BIT] = state_reg.swdiag;

        // channel word comes from the per-channel nibbles built above
        state_next.chan_word = chan_live;

        // image scan: one word per request, output image writes fall away
        // scan_data keeps the last word read until the next request
        state_next.scan_valid = scan_rd_in;
        if (scan_rd_in) begin
            if (scan_word_sel_in == BSW_SEL_CHAN) begin
                state_next.scan_data = state_reg.chan_word;
            end else begin
                state_next.scan_data = state_reg.ext_word;
            end
        end

        // data valid: per block in fast mode, per whole segment otherwise
        // a set and a last-block read in one cycle keep the bit up, so no block is lost
        if (block_rcvd_in && fast_mode_in) begin
            state_next.data_valid = 1'b1;
        end else if (segment_done_in && !fast_mode_in) begin
            state_next.data_valid = 1'b1;
        end else if (last_block_read_in) begin
            state_next.data_valid = 1'b0;
        end

        // the role bit is the first thing each processor reads at start-up
        // the cut-off secondary processor is kept believing it sits on the network
        state_next.role_primary = primary_role_in;
        state_next.presence = !primary_role_in;

        // access point: programming traffic only, one terminal owns the session
        // no session timeout: a terminal that vanishes holds the path until its end frame or until the module loses the primary role
        state_next.relay = 1'b0;
        state_next.reject = 1'b0;
        if (!primary_role_in) begin
            state_next.sess = BSW_SESS_IDLE;
        end else if (to_access_node) begin
            unique case (state_reg.sess)
                BSW_SESS_IDLE: begin
                    if (net_rx_is_prog_in && !net_rx_end_in) begin
                        state_next.relay = 1'b1;
                        state_next.sess = BSW_SESS_OPEN;
                        state_next.sess_owner = net_rx_src_in;
                    end else begin
                        state_next.reject = 1'b1;
                    end
                end
                BSW_SESS_OPEN: begin
                    if (net_rx_is_prog_in && owner_match) begin
                        state_next.relay = 1'b1;
                        if (net_rx_end_in) begin
                            state_next.sess = BSW_SESS_IDLE;
                        end
                    end else begin
                        state_next.reject = 1'b1;
                    end
                end
            endcase
        end

        // remote program on the primary hands control to the partner
        state_next.switchover_req = remote_prog_req_in && primary_role_in;
    end

    // every output leaves a flip-flop, so a scanned word is two edges behind its inputs, the diagnostic bit three
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= '{
                ext_word: BSW_WORD_RST,
                chan_word: BSW_WORD_RST,
                scan_data: BSW_WORD_RST,
                scan_valid: 1'b0,
                swdiag: 1'b0,
                data_valid: 1'b0,
                role_primary: 1'b0,
                sess: BSW_SESS_IDLE,
                sess_owner: BSW_NODE_RST,
                relay: 1'b0,
                reject: 1'b0,
                presence: 1'b0,
                switchover_req: 1'b0
            };
        end else begin
            state_reg <= state_next;
        end
    end

    // scan_wr_in and scan_wr_data_in are deliberately unused: output image is reserved
    assign scan_data_out = state_reg.scan_data;
    assign scan_valid_out = state_reg.scan_valid;
    assign data_valid_out = state_reg.data_valid;
    assign role_primary_out = state_reg.role_primary;
    assign net_relay_out = state_reg.relay;
    assign net_reject_out = state_reg.reject;
    assign presence_emul_out = state_reg.presence;
    assign switchover_req_out = state_reg.switchover_req;

endmodule

/* verification/bsw_status_words_props.sv */
// port assertions for the status word block
`timescale 1ns/1ps
module bsw_status_words_props
    import bsw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in, arst_n_in,
    // watched ports
    input wire logic scan_rd_in, scan_word_sel_in, scan_valid_out,
    input wire logic [BSW_WORD_W-1:0] scan_data_out,
    input wire logic peer_old_rev_in, expansion_present_in, fast_mode_in,
    input wire logic block_rcvd_in, segment_done_in, last_block_read_in, data_valid_out,
    input wire logic primary_role_in, role_primary_out, remote_prog_req_in,
    input wire logic switchover_req_out, net_rx_valid_in, net_relay_out, net_reject_out
);
    default clocking dc @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    logic [1:0] up_reg;
    wire logic set_w = (block_rcvd_in && fast_mode_in) || (segment_done_in && !fast_mode_in);
    wire logic sec_w = net_rx_valid_in && !primary_role_in && !role_primary_out;
    // old samples are trusted only once three edges have passed since reset
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) up_reg <= 2'h0;
        else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
    end
    sequence ext_rd; scan_rd_in && !scan_word_sel_in && up_reg == 2'h3; endsequence
    sequence chan_rd; scan_rd_in && scan_word_sel_in && up_reg == 2'h3; endsequence
    scan_answer_a: assert property (scan_rd_in |=> scan_valid_out)
        else $error("no scan answer");
    ext_reserved_a: assert property (ext_rd |=> scan_data_out[13:10] == 4'h0)
        else $error("reserved bits set");
    peer_rev_a: assert property (ext_rd |=> scan_data_out[8] == $past(peer_old_rev_in, 2))
        else $error("peer bit wrong");
    exp_bit_a: assert property (ext_rd |=> scan_data_out[15] == $past(expansion_present_in, 2))
        else $error("expansion bit wrong");
    chan_gate_a: assert property (chan_rd |=> $past(expansion_present_in, 2) || scan_data_out[7:0] == 8'h00)
        else $error("absent channels not zero");
    dv_set_a: assert property (set_w |=> data_valid_out)
        else $error("data valid not set");
    dv_hold_a: assert property (data_valid_out && !last_block_read_in |=> data_valid_out)
        else $error("data valid dropped");
    dv_clear_a: assert property (last_block_read_in && !set_w |=> !data_valid_out)
        else $error("data valid not cleared");
    role_copy_a: assert property (up_reg == 2'h3 |-> role_primary_out == $past(primary_role_in))
        else $error("role bit wrong");
    sec_quiet_a: assert property (sec_w |=> !net_relay_out && !net_reject_out)
        else $error("secondary answered frame");
    so_req_a: assert property (remote_prog_req_in && primary_role_in && role_primary_out |=> switchover_req_out)
        else $error("no switchover request");
endmodule

/* verification/bsw_proc_model.sv */
// backplane processor model: start-up status read, then bench scans
`timescale 1ns/1ps
module bsw_proc_model (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic req_in,
    input wire logic sel_in,
    output logic rd_out,
    output logic sel_out
);
    logic boot_reg;
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) boot_reg <= 1'h1;
        else boot_reg <= 1'h0;
    end
    // the first edge after release always fetches status before any role routine
    assign rd_out = (boot_reg & arst_n_in) | req_in;
    assign sel_out = sel_in & ~boot_reg;
endmodule

/* verification/tb_bsw_status_words.sv */
// self-checking bench for the status word block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_bsw_status_words;
    import bsw_pkg::*;
    logic clk_sys_in = 1'h0, arst_n_in = 1'h0, req = 1'h0, sel = 1'h0;
    wire logic scan_rd_in, scan_word_sel_in;
    logic scan_wr_in, peer_old_rev_in, fast_mode_in, switchover_active_in, hw_fault_in;
    logic expansion_present_in, primary_role_in, block_rcvd_in, segment_done_in;
    logic last_block_read_in, net_rx_valid_in, net_rx_is_prog_in, net_rx_end_in;
    logic remote_prog_req_in, scan_valid_out, data_valid_out, role_primary_out;
    logic net_relay_out, net_reject_out, presence_emul_out, switchover_req_out;
    logic [15:0] scan_wr_data_in, scan_data_out;
    logic [7:0] bt_status_byte_in;
    logic [11:0] channel_config_switches_in;
    logic [3:0] channel_error_in;
    logic [5:0] node_addr_in, net_rx_dest_in, net_rx_src_in;
    int errors = 0, samples_checked = 0;
    bsw_status_words DUT (.clk_sys_in, .arst_n_in, .scan_rd_in, .scan_word_sel_in, .scan_wr_in,
        .scan_wr_data_in, .scan_data_out, .scan_valid_out, .bt_status_byte_in, .peer_old_rev_in,
        .fast_mode_in, .switchover_active_in, .hw_fault_in, .expansion_present_in,
        .channel_config_switches_in, .channel_error_in, .primary_role_in, .block_rcvd_in,
        .segment_done_in, .last_block_read_in, .data_valid_out, .role_primary_out,
        .node_addr_in, .net_rx_valid_in, .net_rx_dest_in, .net_rx_src_in, .net_rx_is_prog_in,
        .net_rx_end_in, .net_relay_out, .net_reject_out, .presence_emul_out, .remote_prog_req_in,
        .switchover_req_out);
    bsw_proc_model u_proc (.clk_sys_in, .arst_n_in, .req_in(req), .sel_in(sel),
        .rd_out(scan_rd_in), .sel_out(scan_word_sel_in));
    always #4 clk_sys_in = ~clk_sys_in;
    task automatic stop_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic [15:0] ext_exp(input logic d);
        return {expansion_present_in, d, 4'h0, fast_mode_in, peer_old_rev_in, bt_status_byte_in};
    endfunction
    task automatic scan(input logic s, input logic [15:0] exp);
        sel = s;
        req = 1'h1;
        @(negedge clk_sys_in) req = 1'h0;
        `CHK(scan_valid_out, 1'h1)
        `CHK(scan_data_out, exp)
    endtask
    task automatic t_ext();
        for (int i = 0; i < 4; i++) begin
            bt_status_byte_in = 8'h5a ^ 8'(i);
            {fast_mode_in, peer_old_rev_in} = 2'(i);
            expansion_present_in = i[0] ^ i[1];
            scan_wr_in = 1'h1;
            scan_wr_data_in = 16'hffff;
            repeat (2) @(negedge clk_sys_in);
            scan(1'h0, ext_exp(1'h0));
        end
        scan_wr_in = 1'h0;
    endtask
    task automatic t_chan();
        logic [15:0] e;
        channel_config_switches_in = 12'h5c3;
        channel_error_in = 4'h9;
        for (int x = 0; x < 2; x++) begin
            expansion_present_in = x[0];
            for (int k = 0; k < 4; k++)
                e[4*k+:4] = {channel_error_in[k], channel_config_switches_in[3*k+:3]};
            if (x == 0) e[7:0] = 8'h00;
            repeat (2) @(negedge clk_sys_in);
            scan(1'h1, e);
        end
    endtask
    task automatic t_sw();
        logic [2:0] t [4] = '{3'b010, 3'b111, 3'b101, 3'b000};
        foreach (t[i]) begin
            {switchover_active_in, hw_fault_in} = t[i][2:1];
            repeat (3) @(negedge clk_sys_in);
            scan(1'h0, ext_exp(t[i][0]));
        end
    endtask
    task automatic t_dv();
        // fast, block, segment, last, expected level
        logic [4:0] t [7] = '{5'h14, 5'h19, 5'h12, 5'h08, 5'h05, 5'h07, 5'h02};
        foreach (t[i]) begin
            {fast_mode_in, block_rcvd_in, segment_done_in, last_block_read_in} = t[i][4:1];
            @(negedge clk_sys_in) {block_rcvd_in, segment_done_in, last_block_read_in} = 3'h0;
            `CHK(data_valid_out, t[i][0])
            @(negedge clk_sys_in);
        end
    endtask
    task automatic frame(input logic [5:0] s, input logic [3:0] f);
        // f holds programming, end, expected relay, expected refusal
        net_rx_valid_in = 1'h1;
        net_rx_dest_in = node_addr_in + BSW_NODE_STEP;
        net_rx_src_in = s;
        {net_rx_is_prog_in, net_rx_end_in} = f[3:2];
        @(negedge clk_sys_in) net_rx_valid_in = 1'h0;
        `CHK({net_relay_out, net_reject_out}, f[1:0])
        @(negedge clk_sys_in);
    endtask
    task automatic t_net();
        // both processors share node n, so n+1 wraps to zero here
        node_addr_in = 6'h3f;
        remote_prog_req_in = 1'h1;
        repeat (2) @(negedge clk_sys_in);
        `CHK(switchover_req_out, 1'h1)
        `CHK({role_primary_out, presence_emul_out}, 2'h2)
        remote_prog_req_in = 1'h0;
        frame(6'h05, 4'ha);
        `CHK(switchover_req_out, 1'h0)
        frame(6'h07, 4'h9);
        frame(6'h05, 4'h1);
        frame(6'h05, 4'he);
        frame(6'h07, 4'hd);
        primary_role_in = 1'h0;
        remote_prog_req_in = 1'h1;
        repeat (3) @(negedge clk_sys_in);
        `CHK({role_primary_out, presence_emul_out}, 2'h1)
        `CHK(switchover_req_out, 1'h0)
        remote_prog_req_in = 1'h0;
        frame(6'h07, 4'h8);
    endtask
    initial begin
        {scan_wr_in, peer_old_rev_in, fast_mode_in, switchover_active_in, hw_fault_in,
            expansion_present_in, block_rcvd_in, segment_done_in, last_block_read_in,
            net_rx_valid_in, net_rx_is_prog_in, net_rx_end_in, remote_prog_req_in,
            scan_wr_data_in, bt_status_byte_in, channel_config_switches_in,
            channel_error_in, node_addr_in, net_rx_dest_in, net_rx_src_in} = '0;
        primary_role_in = 1'h1;
        repeat (4) @(negedge clk_sys_in);
        arst_n_in = 1'h1;
        @(negedge clk_sys_in);
        `CHK({scan_valid_out, scan_data_out}, 17'h10000)
        t_ext();
        t_chan();
        t_sw();
        t_dv();
        t_net();
        stop_test();
    end
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule
bind bsw_status_words bsw_status_words_props u_props (.clk_sys_in, .arst_n_in, .scan_rd_in,
    .scan_word_sel_in, .scan_valid_out, .scan_data_out, .peer_old_rev_in, .expansion_present_in,
    .fast_mode_in, .block_rcvd_in, .segment_done_in, .last_block_read_in, .data_valid_out,
    .primary_role_in, .role_primary_out, .remote_prog_req_in, .switchover_req_out,
    .net_rx_valid_in, .net_relay_out, .net_reject_out);
